/* File: core/flash_seq.sv */
// Flash lock-and-key program and page-erase sequencer behind an Avalon-MM slave.
// Assumes one system clock; core external-move writes arrive as one-cycle strobes.
// Notes on behaviour
// - Writes and erases are timed internally; no polling needed.
// - Processor stalled for the whole write or erase.
// - Attempt with supply monitor off aborts and requests flash-error reset.
// - Keys 0xA5 then 0xF1 unlock; only that exact pair.
// - Any time gap between the two keys is fine.
// - Wrong or out-of-order key disables modification until reset.
// - Attempt while locked disables modification until reset.
// - Lock returns after every completed write or erase.
// - Write-enable routes external-move writes to flash.
// - Write-enable stays set until software clears it.
// - Byte write only clears bits: new value ANDs with stored.
// - 512-byte pages; erase sets whole page to 0xFF.
// - Unlocked erase with both enables erases addressed page; data ignored.
// - Uninitialised flash cannot be programmed by firmware.
// - Flash-error reset reported as flag in reset-source register.
// - Erase only with both enables; write-enable alone programs bytes.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = `FLASH_ADDR_W,
  parameter int PAGE_BYTES = `FLASH_PAGE_BYTES,
  parameter int WRITE_CYCLES = `FLASH_WRITE_CYCLES,
  parameter int ERASE_CYCLES = `FLASH_ERASE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire xmove_type xmove_i,
  input wire logic supply_monitor_on_i,
  input wire logic flash_initialised_i,
  input wire logic flash_error_seen_i,
  output logic core_stall_o,
  output logic flash_error_reset_o
);
  ////////////////////////////////////////////////////////////////////////////
  localparam int PAGE_W = $clog2(PAGE_BYTES);
  localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
  // Carrier struct fixes the address width, so the array must match it
  if (ADDR_W != `FLASH_ADDR_W)
  begin : bad_width
    $error("flash_seq: array address width must match the external-move carrier");
  end
  if (PAGE_BYTES < 2 || (1 << PAGE_W) != PAGE_BYTES || PAGE_W >= ADDR_W)
  begin : bad_geometry
    $error("flash_seq: page size must be a power of two below the array size");
  end
  // Erase walks one byte per cycle, so it needs at least a page of cycles
  if (WRITE_CYCLES < 1 || ERASE_CYCLES < WRITE_CYCLES || ERASE_CYCLES < PAGE_BYTES)
  begin : bad_timing
    $error("flash_seq: bad operation times");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sampled external levels; supply and init come from other domains
  logic mon_s1_r;
  logic mon_s2_r;
  logic init_s1_r;
  logic init_s2_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mon_s1_r <= 1'b0;
      mon_s2_r <= 1'b0;
      init_s1_r <= 1'b0;
      init_s2_r <= 1'b0;
    end
    else
    begin
      mon_s1_r <= supply_monitor_on_i;
      mon_s2_r <= mon_s1_r;
      init_s1_r <= flash_initialised_i;
      init_s2_r <= init_s1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait cycle so read data come from a register
  logic bus_ack_r;
  logic bus_take;
  logic key_wr;
  logic ctrl_wr;
  logic ptr_wr;
  assign bus_take = (avs_read_i || avs_write_i) && !bus_ack_r;
  assign key_wr = bus_take && avs_write_i && avs_byteenable_i[0]
                  && avs_address_i == `REG_KEY_OFFSET;
  assign ctrl_wr = bus_take && avs_write_i && avs_byteenable_i[0]
                   && avs_address_i == `REG_CONTROL_OFFSET;
  assign ptr_wr = bus_take && avs_write_i && avs_byteenable_i[1:0] == 2'b11
                  && avs_address_i == `REG_READ_POINTER_OFFSET;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bus_ack_r <= 1'b0;
    else
      bus_ack_r <= bus_take;
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !bus_take;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control bits
  logic write_en_r;
  logic erase_en_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      write_en_r <= 1'b0;
      erase_en_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      write_en_r <= avs_writedata_i[`CTRL_WRITE_ENABLE_BIT];
      erase_en_r <= avs_writedata_i[`CTRL_ERASE_ENABLE_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read pointer; lets software inspect the array between operations
  logic [ADDR_W-1:0] read_ptr_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      read_ptr_r <= '0;
    else if (ptr_wr)
      read_ptr_r <= avs_writedata_i[ADDR_W-1:0];
  end
  ////////////////////////////////////////////////////////////////////////////
  // Attempt classification
  op_state_type op_r;
  key_state_type key_r;
  key_state_type key_nxt;
  logic attempt;
  logic attempt_ok;
  logic attempt_no_mon;
  logic attempt_locked;
  assign attempt = xmove_i.valid && write_en_r && op_r == OP_IDLE;
  assign attempt_no_mon = attempt && !mon_s2_r;
  assign attempt_ok = attempt && mon_s2_r && init_s2_r && key_r == KEY_UNLOCKED;
  // Locked attempt also asks for reset; disabling alone would hide the fault
  assign attempt_locked = attempt && mon_s2_r && key_r != KEY_UNLOCKED;
  ////////////////////////////////////////////////////////////////////////////
  // Key machine
  always_comb
  begin
    key_nxt = key_r;
    case (key_r)
      KEY_IDLE:
      begin
        if (attempt)
          key_nxt = KEY_DISABLED;
        else if (key_wr)
          key_nxt = (avs_writedata_i[7:0] == `FLASH_KEY_FIRST) ? KEY_FIRST : KEY_DISABLED;
      end
      KEY_FIRST:
      begin
        // No timeout here: the gap between keys is unbounded
        if (attempt)
          key_nxt = KEY_DISABLED;
        else if (key_wr)
          key_nxt = (avs_writedata_i[7:0] == `FLASH_KEY_SECOND) ? KEY_UNLOCKED : KEY_DISABLED;
      end
      KEY_UNLOCKED:
      begin
        if (key_wr)
          key_nxt = KEY_DISABLED;
        else if (attempt_ok)
          key_nxt = KEY_IDLE;
        else if (attempt)
          key_nxt = KEY_DISABLED;
      end
      KEY_DISABLED:
        key_nxt = KEY_DISABLED;
      default:
        key_nxt = KEY_DISABLED;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      key_r <= KEY_IDLE;
    else
      key_r <= key_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Operation timer and array access
  logic [CNT_W-1:0] cnt_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [7:0] op_data_r;
  logic [ADDR_W-1:0] erase_ptr_r;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic arr_we;
  logic [ADDR_W-1:0] arr_waddr;
  logic [7:0] arr_wdata;
  logic wr_phase_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_r <= OP_IDLE;
      cnt_r <= '0;
      op_addr_r <= '0;
      op_data_r <= 8'h00;
      erase_ptr_r <= '0;
      wr_phase_r <= 1'b0;
    end
    else
    begin
      case (op_r)
        OP_IDLE:
        begin
          if (attempt_ok)
          begin
            op_addr_r <= xmove_i.addr;
            op_data_r <= xmove_i.data;
            wr_phase_r <= 1'b0;
            if (erase_en_r)
            begin
              op_r <= OP_ERASE;
              cnt_r <= CNT_W'(ERASE_CYCLES - 1);
              erase_ptr_r <= {xmove_i.addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
            end
            else
            begin
              op_r <= OP_WRITE;
              cnt_r <= CNT_W'(WRITE_CYCLES - 1);
            end
          end
        end
        OP_WRITE:
        begin
          wr_phase_r <= 1'b1;
          if (cnt_r == '0)
            op_r <= OP_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        OP_ERASE:
        begin
          if (erase_ptr_r[PAGE_W-1:0] != {PAGE_W{1'b1}})
            erase_ptr_r <= erase_ptr_r + 1'b1;
          else
            wr_phase_r <= 1'b1;
          if (cnt_r == '0)
            op_r <= OP_IDLE;
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default:
          op_r <= OP_IDLE;
      endcase
    end
  end
  // Write op reads the old byte first, then stores the AND one cycle later
  // Attempt address wins, so the old byte stands in the first write cycle
  always_comb
  begin
    rd_addr = op_addr_r;
    if (op_r == OP_IDLE)
      rd_addr = xmove_i.valid ? xmove_i.addr : read_ptr_r;
  end
  assign arr_we = (op_r == OP_ERASE && !wr_phase_r)
                  || (op_r == OP_WRITE && !wr_phase_r);
  assign arr_waddr = (op_r == OP_ERASE) ? erase_ptr_r : op_addr_r;
  assign arr_wdata = (op_r == OP_ERASE) ? `FLASH_ERASED_BYTE : (rd_data & op_data_r);
  flash_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .clk_i(clk_i),
    .we_i(arr_we),
    .waddr_i(arr_waddr),
    .wdata_i(arr_wdata),
    .raddr_i(rd_addr),
    .rdata_o(rd_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Stall and error reset
  // Stall rises on the accepting edge so the core never runs ahead
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      core_stall_o <= 1'b0;
    else
      core_stall_o <= attempt_ok || (op_r != OP_IDLE && cnt_r != '0);
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flash_error_reset_o <= 1'b0;
    else
      flash_error_reset_o <= attempt_no_mon || attempt_locked;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `REG_CONTROL_OFFSET:
        rd_mux = {30'h0000_0000, erase_en_r, write_en_r};
      `REG_STATUS_OFFSET:
        rd_mux = {24'h00_0000, op_r != OP_IDLE, key_r == KEY_DISABLED, 2'b00, key_r};
      `REG_RESET_SOURCE_OFFSET:
        rd_mux = {24'h00_0000, 1'b0, flash_error_seen_i, 6'h00};
      `REG_DATA_OFFSET:
        rd_mux = {24'h00_0000, rd_data};
      `REG_READ_POINTER_OFFSET:
        rd_mux = {{(32 - ADDR_W){1'b0}}, read_ptr_r};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (bus_take && avs_read_i)
      avs_readdata_o <= rd_mux;
  end
endmodule
`default_nettype wire

/* File: common/flash_seq_defs.svh */
// Constants of the flash lock-and-key sequencer.
// Assumes inclusion by bare name from the package and the core files.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
`define FLASH_KEY_FIRST 8'hA5
`define FLASH_KEY_SECOND 8'hF1
`define FLASH_ERASED_BYTE 8'hFF
`define FLASH_PAGE_BYTES 512
`define FLASH_ADDR_W 13
`define FLASH_WRITE_TIME_US 40
`define FLASH_ERASE_TIME_US 20000
`define FLASH_CLK_MHZ 25
`define FLASH_WRITE_CYCLES ((`FLASH_WRITE_TIME_US * `FLASH_CLK_MHZ))
`define FLASH_ERASE_CYCLES ((`FLASH_ERASE_TIME_US * `FLASH_CLK_MHZ))
`define REG_KEY_OFFSET 8'h00
`define REG_CONTROL_OFFSET 8'h04
`define REG_STATUS_OFFSET 8'h08
`define REG_RESET_SOURCE_OFFSET 8'h0C
`define REG_DATA_OFFSET 8'h10
`define REG_READ_POINTER_OFFSET 8'h14
`define CTRL_WRITE_ENABLE_BIT 0
`define CTRL_ERASE_ENABLE_BIT 1
`define RESET_SOURCE_REGISTER_FLASH_ERROR_BIT 6
`endif

/* File: common/flash_seq_pkg.sv */
// Types of the flash lock-and-key sequencer.
// Assumes flash_seq_defs.svh is on the include path.
`include "flash_seq_defs.svh"
package flash_seq_pkg;
  typedef enum logic [3:0]
  {
    KEY_IDLE = 4'b0001,
    KEY_FIRST = 4'b0010,
    KEY_UNLOCKED = 4'b0100,
    KEY_DISABLED = 4'b1000
  } key_state_type;
  typedef enum logic [2:0]
  {
    OP_IDLE = 3'b001,
    OP_WRITE = 3'b010,
    OP_ERASE = 3'b100
  } op_state_type;
  typedef struct packed
  {
    logic valid;
    logic [`FLASH_ADDR_W-1:0] addr;
    logic [7:0] data;
  } xmove_type;
endpackage

/* File: core/flash_array.sv */
// Flash byte array with registered read data.
// Assumes one write per cycle from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_array
#(
  parameter int ADDR_W = 13
)
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [ADDR_W-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

/* File: bench/flash_seq_monitor.sv */
// Checker of bus timing, stall length and error pulse of flash_seq.
// Assumes it is bound into flash_seq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor
  import flash_seq_pkg::*;
#(
  parameter int WRITE_CYCLES = 4,
  parameter int ERASE_CYCLES = 600
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire xmove_type xmove_i,
  input wire logic core_stall_o,
  input wire logic flash_error_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [31:0] cnt_r;
  // Counter, since the stall lengths are far beyond a repetition
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      cnt_r <= 32'h0000_0000;
    else
      cnt_r <= core_stall_o ? cnt_r + 32'h0000_0001 : 32'h0000_0000;
  ////////////////////////////////////////
  wait_ans_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest stayed high");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without read");
  err_pulse_a: assert property (flash_error_reset_o |=> !flash_error_reset_o)
    else $error("error reset wider than one cycle");
  err_abort_a: assert property (flash_error_reset_o |-> !core_stall_o)
    else $error("aborted operation still stalls");
  err_cause_a: assert property ($rose(flash_error_reset_o) |->
    $past(xmove_i.valid) || $past(xmove_i.valid, 2) || $past(xmove_i.valid, 3)) else $error("error without attempt");
  stall_cause_a: assert property ($rose(core_stall_o) |-> $past(xmove_i.valid))
    else $error("stall without external move");
  stall_len_a: assert property ($fell(core_stall_o) |-> cnt_r == WRITE_CYCLES || cnt_r == ERASE_CYCLES)
    else $error("stall length wrong");
  stall_cap_a: assert property (cnt_r <= ERASE_CYCLES)
    else $error("stall beyond erase time");
  cover property ($fell(core_stall_o) && cnt_r == WRITE_CYCLES);
  cover property ($fell(core_stall_o) && cnt_r == ERASE_CYCLES);
  cover property (flash_error_reset_o);
endmodule
bind flash_seq flash_seq_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) mon
(
  .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .xmove_i(xmove_i),
  .core_stall_o(core_stall_o), .flash_error_reset_o(flash_error_reset_o)
);
`default_nettype wire

/* File: bench/core_model.sv */
// Processor core model: external-move writes and supply monitor level.
// Assumes the sequencer stalls it while an operation runs.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module core_model
  import flash_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic core_stall_i,
  output var xmove_type xmove_o,
  output logic supply_on_o
);
  // Monitor on at high level, reset source enabled with it
  initial supply_on_o = 1'b1;
  initial xmove_o = '0;
  task automatic issue(input logic [`FLASH_ADDR_W-1:0] a, input logic [7:0] d);
    while (core_stall_i === 1'b1)
      @(posedge clk_i);
    @(posedge clk_i);
    xmove_o <= '{1'b1, a, d};
    @(posedge clk_i);
    // Inverted operands so stale values are never trusted
    xmove_o <= '{1'b0, ~a, ~d};
  endtask
  task automatic set_supply(input logic on);
    @(posedge clk_i);
    supply_on_o <= on;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_flash_lock_key_program_erase.sv */
// Testbench of key sequence, write, erase and error paths of flash_seq.
// Assumes flash_seq, core_model and the monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module test_flash_lock_key_program_erase
  import flash_seq_pkg::*;
;
  localparam int WR = 4;
  localparam int ER = 600;
  localparam logic [7:0] ST = `REG_STATUS_OFFSET;
  localparam logic [7:0] CT = `REG_CONTROL_OFFSET;
  localparam logic [7:0] KY = `REG_KEY_OFFSET;
  localparam logic [7:0] RP = `REG_READ_POINTER_OFFSET;
  localparam logic [7:0] DT = `REG_DATA_OFFSET;
  localparam logic [31:0] M = 32'h0000_00CF;
  logic clk_i = 1'b0, arst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, init = 1'b1, seen = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq, stall, erst, sup;
  xmove_type xm;
  int bad_count = 0, num_checks = 0, cycles = 0;
  always #20 clk_i = ~clk_i;
  flash_seq #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER)) DUT
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .xmove_i(xm), .supply_monitor_on_i(sup), .flash_initialised_i(init), .flash_error_seen_i(seen),
    .core_stall_o(stall), .flash_error_reset_o(erst)
  );
  core_model core (.clk_i(clk_i), .core_stall_i(stall), .xmove_o(xm), .supply_on_o(sup));
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk_i);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("bus answer", 32'h0000_0000, {31'h0, n == 50});
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q & m);
  endtask
  task automatic keys();
    put(KY, 32'h0000_00A5);
    put(KY, 32'h0000_00F1);
  endtask
  task automatic peek(input string what, input logic [31:0] a, input logic [7:0] exp);
    put(RP, a);
    expect_rd(what, DT, 32'h0000_00FF, {24'h00_0000, exp});
  endtask
  task automatic op(input logic [12:0] a, input logic [7:0] d, input int es, input int ee);
    int n;
    int e;
    n = 0;
    e = 0;
    core.issue(a, d);
    for (int i = 0; i < ER + 20; i++)
    begin
      @(negedge clk_i);
      n += int'(stall === 1'b1);
      e += int'(erst === 1'b1);
      if (stall !== 1'b1 && i > 8)
        break;
    end
    chk("stall cycles", es, n);
    if (ee >= 0)
      chk("error pulses", ee, e);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    expect_rd("idle state", ST, M, 32'h0000_0001);
    expect_rd("unmapped read", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    expect_rd("error flag clear", `REG_RESET_SOURCE_OFFSET, 32'h0000_0040, 32'h0000_0000);
  endtask
  task automatic t_write();
    put(KY, 32'h0000_00A5);
    repeat (30) @(posedge clk_i);
    expect_rd("first key held", ST, M, 32'h0000_0002);
    put(KY, 32'h0000_00F1);
    expect_rd("unlocked", ST, M, 32'h0000_0004);
    put(CT, 32'h0000_0001);
    op(13'h0005, 8'h3C, WR, 0);
    expect_rd("relocked", ST, M, 32'h0000_0001);
    expect_rd("enable kept", CT, 32'h0000_0001, 32'h0000_0001);
    op(13'h0006, 8'h11, 0, 1);
    expect_rd("disabled", ST, M, 32'h0000_0048);
    do_reset();
  endtask
  task automatic t_erase();
    keys();
    put(CT, 32'h0000_0002);
    put(CT, 32'h0000_0003);
    op(13'h0200, 8'h00, ER, 0);
    expect_rd("relocked after erase", ST, M, 32'h0000_0001);
    peek("page start erased", 32'h0000_0200, 8'hFF);
    peek("page end erased", 32'h0000_03FF, 8'hFF);
    put(CT, 32'h0000_0000);
    keys();
    op(13'h0201, 8'h00, 0, 0);
    expect_rd("unlock kept", ST, M, 32'h0000_0004);
    put(CT, 32'h0000_0001);
    op(13'h0201, 8'h5A, WR, 0);
    peek("programmed byte", 32'h0000_0201, 8'h5A);
    peek("neighbour untouched", 32'h0000_0202, 8'hFF);
    keys();
    op(13'h0201, 8'h3C, WR, 0);
    peek("bits only cleared", 32'h0000_0201, 8'h18);
    do_reset();
  endtask
  task automatic t_bad_keys();
    logic [7:0] k [4] = '{8'hF1, 8'hA5, 8'hA5, 8'h5A};
    for (int j = 0; j < 4; j += 2)
    begin
      put(KY, {24'h00_0000, k[j]});
      put(KY, {24'h00_0000, k[j + 1]});
      keys();
      expect_rd("stays disabled", ST, M, 32'h0000_0048);
      do_reset();
    end
  endtask
  task automatic t_supply();
    core.set_supply(1'b0);
    keys();
    put(CT, 32'h0000_0001);
    op(13'h0010, 8'h55, 0, 1);
    core.set_supply(1'b1);
    seen <= 1'b1;
    repeat (3) @(posedge clk_i);
    expect_rd("error flag set", `REG_RESET_SOURCE_OFFSET, 32'h0000_0040, 32'h0000_0040);
    seen <= 1'b0;
    do_reset();
  endtask
  task automatic t_uninit();
    init <= 1'b0;
    repeat (3) @(posedge clk_i);
    keys();
    put(CT, 32'h0000_0001);
    op(13'h0020, 8'h00, 0, -1);
    init <= 1'b1;
    do_reset();
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  initial
  begin
    do_reset();
    t_reset();
    t_write();
    t_erase();
    t_bad_keys();
    t_supply();
    t_uninit();
    summarize();
  end
endmodule
`default_nettype wire
